/* File: verilog/tapdu_map.vh */
// Constants of the T=0 command transport sequencer: cases, header codes,
// status bytes and header index and count values.
// Assumes inclusion by bare name from the design files.
`ifndef TAPDU_MAP_VH
`define TAPDU_MAP_VH

`define TAPDU_CASE_1        2'h0
`define TAPDU_CASE_2        2'h1
`define TAPDU_CASE_3        2'h2
`define TAPDU_CASE_4        2'h3

`define TAPDU_P3_ZERO       8'h00
`define TAPDU_GR_CLA        8'h00
`define TAPDU_GR_INS        8'hc0
`define TAPDU_GR_P1         8'h00
`define TAPDU_GR_P2         8'h00

`define TAPDU_SW1_MORE      8'h61
`define TAPDU_SW1_RELEN     8'h6c
`define TAPDU_SW1_WARN_A    8'h62
`define TAPDU_SW1_WARN_B    8'h63
`define TAPDU_SW_OK         16'h9000
`define TAPDU_SW1_APP_NIB   4'h9

`define TAPDU_HDR_LEN       3'h5
`define TAPDU_IDX_P3        3'h4
`define TAPDU_IDX_ZERO      3'h0
`define TAPDU_CNT_ZERO      8'h00
`define TAPDU_CNT_ONE       8'h01

`endif

/* File: verilog/tapdu_sw_class.v */
// Status word classifier for the T=0 sequencer.
// Assumes a completed SW1 SW2 pair on its inputs; purely combinational.
`timescale 1ns/1ps
`include "tapdu_map.vh"

module tapdu_sw_class
(
    input  wire [7:0] sw1,
    input  wire [7:0] sw2,
    output wire       is_more,
    output wire       is_relen,
    output wire       is_ok,
    output wire       is_soft
);

    // Soft status lets a case 4 command go on to fetch its data.
    assign is_more  = (sw1 == `TAPDU_SW1_MORE);
    assign is_relen = (sw1 == `TAPDU_SW1_RELEN);
    assign is_ok    = ({sw1, sw2} == `TAPDU_SW_OK);
    assign is_soft  = (sw1 == `TAPDU_SW1_WARN_A) || (sw1 == `TAPDU_SW1_WARN_B)
                    || ((sw1[7:4] == `TAPDU_SW1_APP_NIB) && !is_ok);

endmodule

/* File: verilog/tapdu_sequencer.v */
// T=0 command transport sequencer between application layer and smart card.
// Assumes a character layer below that sends tx bytes and reports card bytes
// tagged as data, procedure (ACK) or status words, one per pulse.
// Notes on behaviour
// - Consume 61xx and 6Cxx, never forward them; the code forwards them as the trailer in case 1 and 3.
// - Other status ends command, deliver response.
// - Case 4 soft status after data continues.
// - Case 1: header plus P3 zero, stop on status.
// - Case 2: P3 is Le, stop after data, status.
// - Data into body, status unchanged into trailer.
// - Case 3 and 4: P3 is Lc.
// - Procedure byte sends data; status stops command.
// - On 61xx, GET RESPONSE with P3 at most xx.
// - Case 4 soft status gives GET RESPONSE Le zero.
// - GET RESPONSE handled as case 2 exchange.
// - Case 4 trailer holds first status seen.
// - On 6Cxx resend previous header, P3 xx.
// - 61xx and 6Cxx only in case 2, 4.
// - Selection reads carry expected length zero.
// - Expected length zero means up to 256.
`timescale 1ns/1ps
`include "tapdu_map.vh"

module tapdu_sequencer
(
    input  wire       mclk,
    input  wire       arst_n,
    input  wire       cmd_valid,
    input  wire [1:0] cmd_case,
    input  wire [7:0] cmd_cla,
    input  wire [7:0] cmd_ins,
    input  wire [7:0] cmd_p1,
    input  wire [7:0] cmd_p2,
    input  wire [7:0] cmd_lc,
    input  wire [7:0] cmd_le,
    input  wire       cmd_sel_read,
    input  wire [7:0] cmd_data,
    input  wire       tx_ready,
    input  wire       card_data_valid,
    input  wire [7:0] card_data,
    input  wire       card_ack_valid,
    input  wire       card_sw_valid,
    input  wire [7:0] card_sw1,
    input  wire [7:0] card_sw2,
    output reg        cmd_ready_ff,
    output reg        cmd_data_req_ff,
    output reg  [7:0] cmd_data_idx_ff,
    output reg        tx_valid_ff,
    output reg  [7:0] tx_byte_ff,
    output reg        rsp_data_valid_ff,
    output reg  [7:0] rsp_data_ff,
    output reg        rsp_done_ff,
    output reg  [7:0] rsp_sw1_ff,
    output reg  [7:0] rsp_sw2_ff
);

    // ======================================================================
    // State codes
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_HDR   = 3'h1;
    localparam [2:0] ST_WAIT  = 3'h2;
    localparam [2:0] ST_DATA  = 3'h3;
    localparam [2:0] ST_DONE  = 3'h4;

    reg [2:0]  state_ff;
    reg [1:0]  case_ff;
    reg [7:0]  hdr_ff [0:4];
    reg [2:0]  hidx_ff;
    reg [7:0]  lc_ff;
    reg        data_sent_ff;
    reg        in_gr_ff;
    reg        first_sw_ff;
    reg [15:0] first_sw_val_ff;

    wire sw_more;
    wire sw_relen;
    wire sw_ok;
    wire sw_soft;

    tapdu_sw_class u_class
    (
        .sw1      (card_sw1),
        .sw2      (card_sw2),
        .is_more  (sw_more),
        .is_relen (sw_relen),
        .is_ok    (sw_ok),
        .is_soft  (sw_soft)
    );

    // Case 2 and case 4 are the ones that expect response data.
    function data_out_case;
        input [1:0] c;
        begin
            data_out_case = (c == `TAPDU_CASE_2) || (c == `TAPDU_CASE_4);
        end
    endfunction

    wire retrieving = data_out_case(case_ff) || in_gr_ff;

    // ======================================================================
    // Sequencer
    integer i;

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff          <= ST_IDLE;
            case_ff           <= `TAPDU_CASE_1;
            for (i = 0; i < `TAPDU_HDR_LEN; i = i + 1)
                hdr_ff[i] <= `TAPDU_P3_ZERO;
            hidx_ff           <= `TAPDU_IDX_ZERO;
            lc_ff             <= `TAPDU_CNT_ZERO;
            data_sent_ff      <= 1'b0;
            in_gr_ff          <= 1'b0;
            first_sw_ff       <= 1'b0;
            first_sw_val_ff   <= {`TAPDU_P3_ZERO, `TAPDU_P3_ZERO};
            cmd_ready_ff      <= 1'b0;
            cmd_data_req_ff   <= 1'b0;
            cmd_data_idx_ff   <= `TAPDU_CNT_ZERO;
            tx_valid_ff       <= 1'b0;
            tx_byte_ff        <= `TAPDU_P3_ZERO;
            rsp_data_valid_ff <= 1'b0;
            rsp_data_ff       <= `TAPDU_P3_ZERO;
            rsp_done_ff       <= 1'b0;
            rsp_sw1_ff        <= `TAPDU_P3_ZERO;
            rsp_sw2_ff        <= `TAPDU_P3_ZERO;
        end
        else
        begin
            rsp_done_ff       <= 1'b0;
            rsp_data_valid_ff <= 1'b0;
            cmd_data_req_ff   <= 1'b0;
            if (tx_valid_ff && tx_ready)
                tx_valid_ff <= 1'b0;
            // Returned data goes straight to the response body.
            if (card_data_valid && (state_ff == ST_WAIT))
            begin
                rsp_data_valid_ff <= 1'b1;
                rsp_data_ff       <= card_data;
            end
            case (state_ff)
                ST_IDLE:
                begin
                    cmd_ready_ff <= 1'b1;
                    if (cmd_valid && cmd_ready_ff)
                    begin
                        cmd_ready_ff <= 1'b0;
                        case_ff      <= cmd_case;
                        hdr_ff[0]    <= cmd_cla;
                        hdr_ff[1]    <= cmd_ins;
                        hdr_ff[2]    <= cmd_p1;
                        hdr_ff[3]    <= cmd_p2;
                        lc_ff        <= cmd_lc;
                        data_sent_ff <= 1'b0;
                        in_gr_ff     <= 1'b0;
                        first_sw_ff  <= 1'b0;
                        hidx_ff      <= `TAPDU_IDX_ZERO;
                        state_ff     <= ST_HDR;
                        case (cmd_case)
                            `TAPDU_CASE_1: hdr_ff[4] <= `TAPDU_P3_ZERO;
                            `TAPDU_CASE_2: hdr_ff[4] <= cmd_sel_read ?
                                           `TAPDU_P3_ZERO : cmd_le;
                            default:       hdr_ff[4] <= cmd_lc;
                        endcase
                    end
                end
                ST_HDR:
                begin
                    // Five header bytes leave in order from the stored copy.
                    if (!tx_valid_ff || tx_ready)
                    begin
                        tx_valid_ff <= 1'b1;
                        tx_byte_ff  <= hdr_ff[hidx_ff];
                        if (hidx_ff == `TAPDU_IDX_P3)
                            state_ff <= ST_WAIT;
                        else
                            hidx_ff <= hidx_ff + 3'h1;
                    end
                end
                ST_WAIT:
                begin
                    if (card_ack_valid && !in_gr_ff && !data_sent_ff
                        && !data_out_case(case_ff)
                        || card_ack_valid && (case_ff == `TAPDU_CASE_4)
                        && !in_gr_ff && !data_sent_ff)
                    begin
                        if (case_ff[1])
                        begin
                            cmd_data_idx_ff <= `TAPDU_CNT_ZERO;
                            cmd_data_req_ff <= 1'b1;
                            state_ff        <= ST_DATA;
                        end
                    end
                    else if (card_sw_valid)
                    begin
                        if (!first_sw_ff && !(retrieving && (sw_more || sw_relen)))
                        begin
                            first_sw_ff     <= 1'b1;
                            first_sw_val_ff <= {card_sw1, card_sw2};
                        end
                        hidx_ff <= `TAPDU_IDX_ZERO;
                        if (retrieving && sw_relen)
                        begin
                            hdr_ff[4] <= card_sw2;
                            state_ff  <= ST_HDR;
                        end
                        else if (retrieving && sw_more)
                        begin
                            hdr_ff[0] <= `TAPDU_GR_CLA;
                            hdr_ff[1] <= `TAPDU_GR_INS;
                            hdr_ff[2] <= `TAPDU_GR_P1;
                            hdr_ff[3] <= `TAPDU_GR_P2;
                            hdr_ff[4] <= card_sw2;
                            in_gr_ff  <= 1'b1;
                            state_ff  <= ST_HDR;
                        end
                        else if ((case_ff == `TAPDU_CASE_4) && data_sent_ff
                                 && !in_gr_ff && sw_soft)
                        begin
                            hdr_ff[0] <= `TAPDU_GR_CLA;
                            hdr_ff[1] <= `TAPDU_GR_INS;
                            hdr_ff[2] <= `TAPDU_GR_P1;
                            hdr_ff[3] <= `TAPDU_GR_P2;
                            hdr_ff[4] <= `TAPDU_P3_ZERO;
                            in_gr_ff  <= 1'b1;
                            state_ff  <= ST_HDR;
                        end
                        else
                        begin
                            state_ff <= ST_DONE;
                            if ((case_ff == `TAPDU_CASE_4) && first_sw_ff)
                            begin
                                rsp_sw1_ff <= first_sw_val_ff[15:8];
                                rsp_sw2_ff <= first_sw_val_ff[7:0];
                            end
                            else
                            begin
                                rsp_sw1_ff <= card_sw1;
                                rsp_sw2_ff <= card_sw2;
                            end
                        end
                    end
                end
                ST_DATA:
                begin
                    // Command data is sent in one run after the first ACK.
                    if (!tx_valid_ff || tx_ready)
                    begin
                        tx_valid_ff     <= 1'b1;
                        tx_byte_ff      <= cmd_data;
                        if (cmd_data_idx_ff + `TAPDU_CNT_ONE == lc_ff)
                        begin
                            data_sent_ff <= 1'b1;
                            state_ff     <= ST_WAIT;
                        end
                        else
                        begin
                            cmd_data_idx_ff <= cmd_data_idx_ff + `TAPDU_CNT_ONE;
                            cmd_data_req_ff <= 1'b1;
                        end
                    end
                end
                ST_DONE:
                begin
                    if (!tx_valid_ff)
                    begin
                        rsp_done_ff <= 1'b1;
                        state_ff    <= ST_IDLE;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

endmodule

/* File: tb/tapdu_seq_monitor.sv */
// Checker for the T=0 command sequencer, bound to its top module.
// Assumes the port names of tapdu_sequencer and a single clock domain.
`timescale 1ns/1ps
module tapdu_seq_monitor
(
    input wire       mclk,
    input wire       arst_n,
    input wire       cmd_valid,
    input wire [1:0] cmd_case,
    input wire [7:0] cmd_cla,
    input wire       tx_ready,
    input wire       card_data_valid,
    input wire       card_sw_valid,
    input wire       cmd_ready_ff,
    input wire       cmd_data_req_ff,
    input wire       tx_valid_ff,
    input wire [7:0] tx_byte_ff,
    input wire       rsp_data_valid_ff,
    input wire       rsp_done_ff,
    input wire [7:0] rsp_sw1_ff,
    input wire [7:0] rsp_sw2_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence s_take;
        cmd_valid && cmd_ready_ff;
    endsequence
    sequence s_first_byte;
        ##[1:2] tx_valid_ff && tx_byte_ff == cmd_cla;
    endsequence
    AST_TAKE_START: assert property (s_take |-> s_first_byte)
        else $error("header does not start with the class byte");
    AST_DONE_AFTER_SW: assert property (rsp_done_ff |-> $past(card_sw_valid)
        || $past(card_sw_valid, 2)) else $error("completion without card status");
    AST_DONE_PULSE: assert property (rsp_done_ff |=> !rsp_done_ff)
        else $error("completion longer than one cycle");
    AST_NO_FWD: assert property (rsp_done_ff |-> rsp_sw1_ff != 8'h61
        && rsp_sw1_ff != 8'h6c) else $error("procedure bytes forwarded");
    AST_TRAILER_HOLD: assert property ($changed({rsp_sw1_ff, rsp_sw2_ff})
        |-> ##[1:2] rsp_done_ff) else $error("trailer changed outside completion");
    AST_TX_HOLD: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff
        && $stable(tx_byte_ff)) else $error("tx byte dropped before acceptance");
    AST_NO_DATA_REQ: assert property (!cmd_ready_ff && cmd_case < 2'h2 |-> !cmd_data_req_ff)
        else $error("command data requested without body");
    AST_RSP_DATA: assert property (card_data_valid && !cmd_ready_ff
        |-> ##[1:2] rsp_data_valid_ff) else $error("card data not passed on");
endmodule
bind tapdu_sequencer tapdu_seq_monitor tapdu_seq_monitor_i
(
    .mclk              (mclk),
    .arst_n            (arst_n),
    .cmd_valid         (cmd_valid),
    .cmd_case          (cmd_case),
    .cmd_cla           (cmd_cla),
    .tx_ready          (tx_ready),
    .card_data_valid   (card_data_valid),
    .card_sw_valid     (card_sw_valid),
    .cmd_ready_ff      (cmd_ready_ff),
    .cmd_data_req_ff   (cmd_data_req_ff),
    .tx_valid_ff       (tx_valid_ff),
    .tx_byte_ff        (tx_byte_ff),
    .rsp_data_valid_ff (rsp_data_valid_ff),
    .rsp_done_ff       (rsp_done_ff),
    .rsp_sw1_ff        (rsp_sw1_ff),
    .rsp_sw2_ff        (rsp_sw2_ff)
);

/* File: tb/tapdu_card_model.sv */
// Behavioural smart card answering T=0 headers from a scripted plan.
// Assumes the bench pushes one answer word per header, plus one more after an ACK word, before each command.
`timescale 1ns/1ps
module tapdu_card_model
(
    input  wire       mclk,
    input  wire       slow,
    input  wire       tx_valid,
    input  wire [7:0] tx_byte,
    output reg        tx_ready = 1'b0,
    output reg        data_valid = 1'b0,
    output reg  [7:0] data = 8'h00,
    output reg        ack_valid = 1'b0,
    output reg        sw_valid = 1'b0,
    output reg  [7:0] sw1 = 8'h00,
    output reg  [7:0] sw2 = 8'h00
);
    logic [15:0] plan[$];
    logic [15:0] w;
    logic [7:0]  hdr[5];
    logic [7:0]  d;
    // Slow mode accepts only every other cycle.
    always @(posedge mclk)
        tx_ready <= slow ? !tx_ready : 1'b1;
    task get(output logic [7:0] b);
        @(posedge mclk);
        while (!(tx_valid && tx_ready))
            @(posedge mclk);
        b = tx_byte;
    endtask
    // Kind 0 is data, 1 a procedure byte, 2 a status pair; lines invert after.
    task put(input logic [1:0] k, input logic [15:0] v);
        @(posedge mclk);
        {data_valid, ack_valid, sw_valid} <= {k == 2'h0, k == 2'h1, k == 2'h2};
        {data, sw1, sw2} <= {v[7:0], v};
        @(posedge mclk);
        {data_valid, ack_valid, sw_valid} <= 3'h0;
        {data, sw1, sw2} <= ~{v[7:0], v};
    endtask
    always
    begin
        for (int i = 0; i < 5; i++)
            get(hdr[i]);
        w = plan.pop_front();
        if (w == 16'hac00)
        begin
            put(2'h1, 16'h0000);
            for (int i = 0; i < hdr[4]; i++)
                get(d);
            w = plan.pop_front();
        end
        if (w == 16'hd000)
        begin
            for (int i = 0; i < (hdr[4] == 8'h00 ? 256 : hdr[4]); i++)
                put(2'h0, 16'(8'ha0 + i));
            w = 16'h9000;
        end
        put(2'h2, w);
    end
endmodule

/* File: tb/tb_t0_apdu_transport_sequencer.sv */
// Self-checking bench for the T=0 command sequencer against a card model.
// Assumes the design, the checker and the card model are compiled first.
`timescale 1ns/1ps
module tb_t0_apdu_transport_sequencer;
    reg        mclk = 1'b0;
    reg        arst_n = 1'b0;
    reg        slow = 1'b0;
    reg        cmd_valid = 1'b0;
    reg        cmd_sel_read = 1'b0;
    reg  [1:0] cmd_case = 2'h0;
    reg  [7:0] cmd_cla = 8'h00, cmd_ins = 8'h00, cmd_p1 = 8'h00, cmd_p2 = 8'h00;
    reg  [7:0] cmd_lc = 8'h00, cmd_le = 8'h00;
    wire       tx_ready, card_data_valid, card_ack_valid, card_sw_valid;
    wire [7:0] card_data, card_sw1, card_sw2, cmd_data_idx_ff, tx_byte_ff;
    wire       cmd_ready_ff, cmd_data_req_ff, tx_valid_ff, rsp_data_valid_ff, rsp_done_ff;
    wire [7:0] rsp_data_ff, rsp_sw1_ff, rsp_sw2_ff;
    wire [7:0] cmd_data = 8'h50 + cmd_data_idx_ff;
    logic [7:0]  txq[$], rq[$];
    logic [15:0] sw;
    int          fails = 0, compares = 0;
    tapdu_sequencer tapdu_sequencer_i (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_case(cmd_case), .cmd_cla(cmd_cla), .cmd_ins(cmd_ins), .cmd_p1(cmd_p1),
        .cmd_p2(cmd_p2), .cmd_lc(cmd_lc), .cmd_le(cmd_le), .cmd_sel_read(cmd_sel_read),
        .cmd_data(cmd_data), .tx_ready(tx_ready), .card_data_valid(card_data_valid),
        .card_data(card_data), .card_ack_valid(card_ack_valid),
        .card_sw_valid(card_sw_valid), .card_sw1(card_sw1), .card_sw2(card_sw2),
        .cmd_ready_ff(cmd_ready_ff), .cmd_data_req_ff(cmd_data_req_ff),
        .cmd_data_idx_ff(cmd_data_idx_ff), .tx_valid_ff(tx_valid_ff),
        .tx_byte_ff(tx_byte_ff), .rsp_data_valid_ff(rsp_data_valid_ff),
        .rsp_data_ff(rsp_data_ff), .rsp_done_ff(rsp_done_ff), .rsp_sw1_ff(rsp_sw1_ff),
        .rsp_sw2_ff(rsp_sw2_ff));
    tapdu_card_model tapdu_card_model_i (.mclk(mclk), .slow(slow), .tx_valid(tx_valid_ff),
        .tx_byte(tx_byte_ff), .tx_ready(tx_ready), .data_valid(card_data_valid),
        .data(card_data), .ack_valid(card_ack_valid), .sw_valid(card_sw_valid),
        .sw1(card_sw1), .sw2(card_sw2));
    always #4 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (tx_valid_ff && tx_ready)
            txq.push_back(tx_byte_ff);
        if (rsp_data_valid_ff)
            rq.push_back(rsp_data_ff);
    end
    task end_sim;
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_q(input string n, input logic [7:0] e[$], input logic [7:0] g[$]);
        chk({n, " count"}, 16'(e.size()), 16'(g.size()));
        foreach (e[k])
            chk(n, {8'h00, e[k]}, {8'h00, g[k]});
    endtask
    task automatic run(input logic [1:0] c, input logic [7:0] cl, i, a, b, lc, le,
                       input logic sel);
        txq.delete();
        rq.delete();
        @(posedge mclk);
        {cmd_case, cmd_cla, cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le} <= {c, cl, i, a, b, lc, le};
        {cmd_sel_read, cmd_valid} <= {sel, 1'b1};
        do
            @(posedge mclk);
        while (cmd_ready_ff !== 1'b1);
        cmd_valid <= 1'b0;
        do
            @(posedge mclk);
        while (rsp_done_ff !== 1'b1);
        sw = {rsp_sw1_ff, rsp_sw2_ff};
    endtask
    task sc_case1;
        tapdu_card_model_i.plan = '{16'h6a82};
        run(2'h0, 8'h80, 8'hca, 8'h01, 8'h02, 8'h07, 8'h09, 1'b0);
        chk_q("tx", '{8'h80, 8'hca, 8'h01, 8'h02, 8'h00}, txq);
        chk("sw", 16'h6a82, sw);
        chk("rsp count", 16'h0000, 16'(rq.size()));
    endtask
    task sc_case2_relen;
        slow <= 1'b1;
        tapdu_card_model_i.plan = '{16'h6c04, 16'hd000};
        run(2'h1, 8'h80, 8'hb2, 8'h01, 8'h0c, 8'h00, 8'h00, 1'b0);
        chk_q("tx", '{8'h80, 8'hb2, 8'h01, 8'h0c, 8'h00, 8'h80, 8'hb2, 8'h01, 8'h0c, 8'h04},
              txq);
        chk_q("rsp", '{8'ha0, 8'ha1, 8'ha2, 8'ha3}, rq);
        chk("sw", 16'h9000, sw);
        slow <= 1'b0;
    endtask
    task sc_sel_read;
        tapdu_card_model_i.plan = '{16'h6a83};
        run(2'h1, 8'h00, 8'hb2, 8'h02, 8'h14, 8'h00, 8'h1d, 1'b1);
        chk_q("tx", '{8'h00, 8'hb2, 8'h02, 8'h14, 8'h00}, txq);
        chk("sw", 16'h6a83, sw);
    endtask
    task sc_case3_stop;
        tapdu_card_model_i.plan = '{16'h6985};
        run(2'h2, 8'h80, 8'he2, 8'h00, 8'h00, 8'h03, 8'h00, 1'b0);
        chk_q("tx", '{8'h80, 8'he2, 8'h00, 8'h00, 8'h03}, txq);
        chk("sw", 16'h6985, sw);
    endtask
    task sc_case4_more;
        tapdu_card_model_i.plan = '{16'hac00, 16'h6105, 16'hd000};
        run(2'h3, 8'h00, 8'ha4, 8'h04, 8'h00, 8'h02, 8'h00, 1'b0);
        chk_q("tx", '{8'h00, 8'ha4, 8'h04, 8'h00, 8'h02, 8'h50, 8'h51, 8'h00, 8'hc0, 8'h00,
              8'h00, 8'h05}, txq);
        chk_q("rsp", '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4}, rq);
        chk("sw", 16'h9000, sw);
    endtask
    task sc_case4_soft;
        tapdu_card_model_i.plan = '{16'hac00, 16'h6283, 16'hd000};
        run(2'h3, 8'h80, 8'ha8, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0);
        chk_q("tx", '{8'h80, 8'ha8, 8'h00, 8'h00, 8'h01, 8'h50, 8'h00, 8'hc0, 8'h00, 8'h00,
              8'h00}, txq);
        chk("sw", 16'h6283, sw);
        chk("rsp count", 16'h0100, 16'(rq.size()));
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        sc_case1;
        sc_case2_relen;
        sc_sel_read;
        sc_case3_stop;
        sc_case4_more;
        sc_case4_soft;
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_sim;
    end
endmodule
